/* src/ppc_pkg.sv */
// Package for the primary bus port core: constants, types and the contract list.
// Contract
// - Time and sample everything on primary clock rise.
// - Under reset float drivers, clear all registers.
// - Under reset take part in nothing.
// - Under reset drive secondary signals low.
// - After reset start from default state.
// - Address/data lines carry address, then data.
// - Command sits on C/BE lines in address phase.
// - C/BE lines are byte enables in data phases.
// - Enable line n governs data byte n.
// - Even parity over AD and C/BE, one clock later.
// - Data phase completes only when both readies asserted.
package ppc_pkg;
	// ****************************************************************
	// Widths and encodings
	// ****************************************************************
	localparam int ADDR_DATA_W = 32;
	localparam int CBE_W = 4;
	localparam int BYTE_W = 8;
	localparam int SEC_W = 8;
	localparam logic [3:0] CBE_RESET = 4'h0;
	localparam logic [31:0] AD_RESET = 32'h0000_0000;
	localparam logic [3:0] CMD_MEM_READ = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;

	// Phase machine, one-hot.
	typedef enum logic [2:0] {
		PPC_IDLE = 3'b001,
		PPC_ADDR = 3'b010,
		PPC_DATA = 3'b100
	} ppc_phase_t;

	// Primary pin group as seen from the core: address/data, command/enables, parity.
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0] cbe_n;
		logic par;
	} ppc_pins_t;

	// Decoded record of one completed data phase.
	typedef struct packed {
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [31:0] data;
		logic [3:0] lane_en;
	} ppc_xfer_t;
endpackage : ppc_pkg

/* src/ppc_sync3.sv */
// Three-stage input synchroniser for a group of W primary pin levels.
`timescale 1ns/100ps
`default_nettype none
module ppc_sync3 #(
	parameter int W = 1
) (
	input wire logic mclk, // Primary bus clock.
	input wire logic reset, // Synchronous reset, active high.
	input wire logic [W-1:0] din, // Raw pin level.
	output logic [W-1:0] dout // Agreed level.
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] dout_reg;

	// ****************************************************************
	// Stages
	// ****************************************************************
	// A change only counts when stages two and three agree, which filters a late flip.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			dout_reg <= '0;
		end
		else
		begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < W; i++)
			begin
				if (s2_reg[i] == s3_reg[i])
					dout_reg[i] <= s3_reg[i];
			end
		end
	end
	assign dout = dout_reg;
endmodule : ppc_sync3
`default_nettype wire

/* src/ppc_core.sv */
// Primary bus port core: pin sampling, reset behaviour, phase decode and parity.
`timescale 1ns/100ps
`default_nettype none
module ppc_core (
	input wire logic mclk, // Primary bus clock.
	input wire logic reset, // Primary bus reset, synchronous, active high.
	input wire logic frame_n_i, // Cycle frame pin, active low.
	input wire logic [31:0] primary_addr_data_bus_i, // Address/data pins in.
	input wire logic [3:0] primary_cmd_byte_enables_i, // Command/enable pins in.
	input wire logic primary_initiator_ready_n_i, // Initiator ready pin, active low.
	input wire logic primary_target_ready_n_i, // Target ready pin, active low.
	input wire logic user_drive, // User asks to drive a write cycle.
	input wire logic [31:0] user_ad, // Word to drive when driving.
	input wire logic [3:0] user_cbe_n, // Command or enables to drive.
	output logic [31:0] primary_addr_data_bus_o, // Address/data pins out.
	output logic [3:0] primary_cmd_byte_enables_o, // Command/enable pins out.
	output logic primary_bus_oe, // Enable for AD and C/BE drivers.
	output logic primary_parity_bit_o, // Parity pin out.
	output logic primary_parity_bit_oe, // Parity pin enable.
	output logic [7:0] secondary_out, // Secondary interface outputs.
	output logic xfer_valid, // One-cycle pulse: a data phase completed.
	output var ppc_pkg::ppc_xfer_t xfer // Completed data phase record.
);
	typedef struct packed {
		ppc_pkg::ppc_phase_t phase;
		logic [31:0] addr;
		logic [3:0] cmd;
		logic [31:0] ad_out;
		logic [3:0] cbe_out;
		logic oe;
		logic par;
		logic par_oe;
		logic [7:0] sec;
		logic xv;
		ppc_pkg::ppc_xfer_t xf;
	} ppc_state_t;

	ppc_state_t st_reg;
	ppc_state_t st_next;
	logic [38:0] pins_s;
	logic frame_n;
	logic irdy_n;
	logic trdy_n;
	logic [31:0] ad_s;
	logic [3:0] cbe_s;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	// All pins are sampled on the rising clock edge only.
	// Active-low controls pass inverted, so a cleared synchroniser reads as an idle bus.
	ppc_sync3 #(.W(39)) u_sync (
		.mclk(mclk),
		.reset(reset),
		.din({~frame_n_i, ~primary_initiator_ready_n_i, ~primary_target_ready_n_i,
			primary_addr_data_bus_i, primary_cmd_byte_enables_i}),
		.dout(pins_s)
	);
	assign frame_n = ~pins_s[38];
	assign irdy_n = ~pins_s[37];
	assign trdy_n = ~pins_s[36];
	assign ad_s = pins_s[35:4];
	assign cbe_s = pins_s[3:0];

	// ****************************************************************
	// Next state
	// ****************************************************************
	// Lane mask expands active-low enables: line n governs byte n.
	function automatic logic [31:0] lane_mask(input logic [3:0] cbe_n);
		logic [31:0] m;
		m = '0;
		for (int n = 0; n < ppc_pkg::CBE_W; n++)
			m[n*ppc_pkg::BYTE_W +: ppc_pkg::BYTE_W] = {8{~cbe_n[n]}};
		return m;
	endfunction : lane_mask

	// The state machine follows the sampled bus; data are masked to enabled lanes.
	always_comb
	begin
		st_next = st_reg;
		st_next.xv = 1'b0;
		// Parity covers what was driven last cycle, so it trails by one clock.
		st_next.par = ^{st_reg.ad_out, st_reg.cbe_out};
		st_next.par_oe = st_reg.oe;
		st_next.oe = user_drive;
		// The drive word is taken only while driving, so a floated bus keeps its last word.
		if (user_drive)
		begin
			st_next.ad_out = user_ad;
			st_next.cbe_out = user_cbe_n;
		end
		case (st_reg.phase)
			ppc_pkg::PPC_IDLE:
			begin
				if (!frame_n)
				begin
					// Address phase: AD holds the address, C/BE the command.
					st_next.addr = ad_s;
					st_next.cmd = cbe_s;
					st_next.phase = ppc_pkg::PPC_DATA;
				end
			end
			ppc_pkg::PPC_ADDR:
				st_next.phase = ppc_pkg::PPC_DATA;
			ppc_pkg::PPC_DATA:
			begin
				// Waits are inserted until both readies are low together.
				if (!irdy_n && !trdy_n)
				begin
					st_next.xv = 1'b1;
					st_next.xf.addr = st_reg.addr;
					st_next.xf.cmd = st_reg.cmd;
					st_next.xf.data = ad_s & lane_mask(cbe_s);
					st_next.xf.lane_en = ~cbe_s;
					if (frame_n)
						st_next.phase = ppc_pkg::PPC_IDLE;
				end
			end
			default:
				st_next.phase = ppc_pkg::PPC_IDLE;
		endcase
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	// Reset floats drivers, clears state, holds secondary low and blocks all activity.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			st_reg <= '0;
			st_reg.phase <= ppc_pkg::PPC_IDLE;
			st_reg.ad_out <= ppc_pkg::AD_RESET;
			st_reg.cbe_out <= ppc_pkg::CBE_RESET;
			st_reg.sec <= '0;
		end
		else
			st_reg <= st_next;
	end

	assign primary_addr_data_bus_o = st_reg.ad_out;
	assign primary_cmd_byte_enables_o = st_reg.cbe_out;
	assign primary_bus_oe = st_reg.oe;
	assign primary_parity_bit_o = st_reg.par;
	assign primary_parity_bit_oe = st_reg.par_oe;
	assign secondary_out = st_reg.sec;
	assign xfer_valid = st_reg.xv;
	assign xfer = st_reg.xf;

	// ****************************************************************
	// Checks
	// ****************************************************************
	property p_reset_float;
		@(posedge mclk) reset |=> !primary_bus_oe && !primary_parity_bit_oe;
	endproperty
	a_reset_float: assert property (p_reset_float) else $error("drivers not floated");

	property p_reset_quiet;
		@(posedge mclk) reset |=> !xfer_valid;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("activity under reset");

	property p_sec_low;
		@(posedge mclk) reset |=> secondary_out == 8'h00;
	endproperty
	a_sec_low: assert property (p_sec_low) else $error("secondary not low");

	property p_default;
		@(posedge mclk) $fell(reset) |-> st_reg.phase == ppc_pkg::PPC_IDLE;
	endproperty
	a_default: assert property (p_default) else $error("not default after reset");

	property p_parity;
		@(posedge mclk) disable iff (reset)
		primary_bus_oe |=> primary_parity_bit_oe &&
			primary_parity_bit_o == ^{$past(primary_addr_data_bus_o),
			$past(primary_cmd_byte_enables_o)};
	endproperty
	a_parity: assert property (p_parity) else $error("parity wrong");

	property p_ready;
		@(posedge mclk) disable iff (reset)
		xfer_valid |-> $past(!irdy_n && !trdy_n);
	endproperty
	a_ready: assert property (p_ready) else $error("phase without both readies");

	property p_lanes;
		@(posedge mclk) disable iff (reset)
		xfer_valid |-> (xfer.data & ~lane_mask(~xfer.lane_en)) == 32'h0000_0000;
	endproperty
	a_lanes: assert property (p_lanes) else $error("disabled lane carries data");

	property p_enables;
		@(posedge mclk) disable iff (reset)
		xfer_valid |-> xfer.lane_en == ~$past(cbe_s);
	endproperty
	a_enables: assert property (p_enables) else $error("enable polarity wrong");

	property primary_parity_bit_lag;
		@(posedge mclk) disable iff (reset)
		!primary_bus_oe |=> !primary_parity_bit_oe;
	endproperty
	a_par_lag: assert property (primary_parity_bit_lag) else $error("parity drive stray");

	property p_reset_values;
		@(posedge mclk) $fell(reset) |-> primary_addr_data_bus_o == ppc_pkg::AD_RESET &&
			primary_cmd_byte_enables_o == ppc_pkg::CBE_RESET && !xfer_valid;
	endproperty
	a_reset_values: assert property (p_reset_values) else $error("not reset values");

	property p_wake_quiet;
		@(posedge mclk) $fell(reset) |-> !xfer_valid [*5];
	endproperty
	a_wake_quiet: assert property (p_wake_quiet) else $error("early completion");

	property p_wait;
		@(posedge mclk) disable iff (reset)
		st_reg.phase == ppc_pkg::PPC_DATA && (irdy_n || trdy_n) |=> !xfer_valid;
	endproperty
	a_wait: assert property (p_wait) else $error("completion during wait");

	property p_capture;
		@(posedge mclk) disable iff (reset)
		st_reg.phase == ppc_pkg::PPC_IDLE && !frame_n |=>
			st_reg.addr == $past(ad_s) && st_reg.cmd == $past(cbe_s);
	endproperty
	a_capture: assert property (p_capture) else $error("address not captured");
endmodule : ppc_core
`default_nettype wire

/* tb/ppc_host.sv */
// Primary bus agent model that frames one-data-phase cycles on the pins.
`timescale 1ns/100ps
`default_nettype none
module ppc_host (
	input wire logic mclk, // Primary bus clock.
	output logic frame_n, // Cycle frame, active low.
	output logic [31:0] ad, // Address/data pins.
	output logic [3:0] cbe_n, // Command/enable pins.
	output logic irdy_n, // Initiator ready, active low.
	output logic trdy_n // Target ready, active low.
);
	// Idle bus levels at time zero.
	initial
	begin
		frame_n = 1'b1;
		ad = 32'h0000_0000;
		cbe_n = 4'hf;
		irdy_n = 1'b1;
		trdy_n = 1'b1;
	end

	// Pins move on the falling edge so the core samples them on the rise.
	// Phases are held for six cycles, as the core sees pins four edges late.
	task automatic cycle(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
		input logic [3:0] be_n, input int w);
		@(negedge mclk);
		frame_n <= 1'b0;
		ad <= a;
		cbe_n <= c;
		repeat (6) @(negedge mclk);
		frame_n <= 1'b1;
		ad <= d;
		cbe_n <= be_n;
		irdy_n <= 1'b0;
		repeat (w) @(negedge mclk);
		trdy_n <= 1'b0;
		repeat (6) @(negedge mclk);
		irdy_n <= 1'b1;
		trdy_n <= 1'b1;
		// A released bus shows the inverse, so stale values cannot pass.
		ad <= ~d;
		cbe_n <= ~be_n;
	endtask : cycle
endmodule : ppc_host
`default_nettype wire

/* tb/tb.sv */
// Self-checking testbench for the primary bus port core.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic user_drive = 1'b0;
	logic [31:0] user_ad = 32'h0000_0000;
	logic [3:0] user_cbe_n = 4'h0;
	logic frame_n, irdy_n, trdy_n, oe, par, par_oe, xv;
	logic [31:0] ad, ad_o;
	logic [3:0] cbe_n, cbe_o;
	logic [7:0] sec;
	ppc_pkg::ppc_xfer_t xf;
	int error_cnt = 0;
	int check_count = 0;

	// Clock of 10 ns period.
	always #5 mclk = ~mclk;

	ppc_host ppc_host_inst (.mclk(mclk), .frame_n(frame_n), .ad(ad), .cbe_n(cbe_n),
		.irdy_n(irdy_n), .trdy_n(trdy_n));
	ppc_core ppc_core_inst (.mclk(mclk), .reset(reset), .frame_n_i(frame_n),
		.primary_addr_data_bus_i(ad), .primary_cmd_byte_enables_i(cbe_n),
		.primary_initiator_ready_n_i(irdy_n), .primary_target_ready_n_i(trdy_n),
		.user_drive(user_drive), .user_ad(user_ad), .user_cbe_n(user_cbe_n),
		.primary_addr_data_bus_o(ad_o), .primary_cmd_byte_enables_o(cbe_o),
		.primary_bus_oe(oe), .primary_parity_bit_o(par), .primary_parity_bit_oe(par_oe),
		.secondary_out(sec), .xfer_valid(xv), .xfer(xf));

	// Counts a comparison and reports a mismatch at once.
	task automatic check(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	// One framed cycle; waits until target ready, then times the completion.
	task automatic t_xfer(input logic [31:0] a, input logic [3:0] c, input logic [31:0] d,
		input logic [3:0] be_n, input int w);
		logic [31:0] m;
		logic early;
		int n;
		m = 32'h0000_0000;
		early = 1'b0;
		n = 0;
		for (int i = 0; i < 4; i++)
			if (!be_n[i])
				m[8*i +: 8] = 8'hff;
		fork
			ppc_host_inst.cycle(a, c, d, be_n, w);
			begin
				// Step first: a previous call may still leave target ready low in this time step.
				do
				begin
					@(negedge mclk);
					early = early | (xv === 1'b1);
					n++;
				end
				while (trdy_n !== 1'b0 && n < 100);
				n = 0;
				while (xv !== 1'b1 && n < 20)
				begin
					@(negedge mclk);
					n++;
				end
			end
		join
		check(!early && n >= 2 && n <= 8, "completion timing");
		check(xv === 1'b0, "single pulse");
		check(xf.addr === a, "address");
		check(xf.cmd === c, "command");
		check(xf.data === (d & m), "lane data");
		check(xf.lane_en === ~be_n, "lane enables");
	endtask : t_xfer

	// Drives a word; parity follows one clock after the values.
	task automatic t_drive(input logic [31:0] v, input logic [3:0] c);
		@(negedge mclk);
		user_drive = 1'b1;
		user_ad = v;
		user_cbe_n = c;
		@(negedge mclk);
		check(oe === 1'b1 && ad_o === v && cbe_o === c, "drive");
		@(negedge mclk);
		check(par_oe === 1'b1 && par === ^{v, c}, "parity");
		user_drive = 1'b0;
		repeat (2) @(negedge mclk);
		check(oe === 1'b0 && par_oe === 1'b0, "release");
	endtask : t_drive

	// Reset in mid-drive must float drivers and restore defaults.
	task automatic t_rst_mid;
		user_drive = 1'b1;
		repeat (3) @(negedge mclk);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		check(oe === 1'b0 && par_oe === 1'b0 && xv === 1'b0, "float");
		check(sec === 8'h00, "secondary low");
		reset = 1'b0;
		user_drive = 1'b0;
		repeat (2) @(negedge mclk);
		check(oe === 1'b0 && ad_o === ppc_pkg::AD_RESET && cbe_o === ppc_pkg::CBE_RESET, "default");
	endtask : t_rst_mid

	// Main sequence.
	initial
	begin
		repeat (16) @(negedge mclk);
		check(oe === 1'b0 && par_oe === 1'b0 && sec === 8'h00, "in reset");
		reset = 1'b0;
		t_xfer(32'h1000_0040, ppc_pkg::CMD_MEM_READ, 32'ha1b2_c3d4, 4'h0, 0);
		t_xfer(32'h2000_0044, ppc_pkg::CMD_MEM_WRITE, 32'h5566_7788, 4'he, 8);
		t_xfer(32'h3000_0048, ppc_pkg::CMD_MEM_READ, 32'h99aa_bbcc, 4'hd, 2);
		t_drive(32'h0000_0001, 4'h0);
		t_drive(32'h0000_0003, 4'h3);
		t_rst_mid();
		t_xfer(32'h4000_004c, ppc_pkg::CMD_MEM_WRITE, 32'hddee_ff01, 4'hb, 1);
		t_xfer(32'h5000_0050, ppc_pkg::CMD_MEM_READ, 32'h1234_5678, 4'h7, 0);
		test_done();
	end

	// Watchdog, far beyond the hundred or so cycles the tests need.
	initial
	begin
		#200000;
		error_cnt++;
		test_done();
	end
endmodule : tb
`default_nettype wire
